// ---- core/otgtc_top.sv ----
// Notes on behaviour
// - Data pins float when enable low or in pass modes, else driven.
// - Shared pin carries encoded data or plus level.
// - Device is slave only; controller starts accesses.
// - Pump drives, weakly pulls up, or discharges.
// - ID floating, grounded, or resistor clears both.
// - ID status stays valid in suspend.
// - ID switch follows its control bit.
// - Four independent line pull resistors.
// - USB mode uses differential and single-ended paths.
// - Pass or UART modes route levels unencoded.
// - Carkit indication only while audio enabled.
// - Supply-valid low flags a supply fault.
// - Session-end flags supply below end threshold.
// - With both pass bits clear, enable selects direction.
// - Active-low asynchronous reset clears all logic.
`timescale 1ns/1ps
module otgtc_top (
  // Clock and reset
  input  wire logic       CLK,
  input  wire logic       RST,
  input  wire logic       RESET_N,
  // Control bits written by the controller
  input  wire logic       TRANSPARENT_MODE_ENABLE,
  input  wire logic       UART_ENABLE,
  input  wire logic       ENCODED_DATA_USB_MODE,
  input  wire logic       AUDIO_ENABLE,
  input  wire logic       SUSPEND_REQ,
  input  wire logic       ID_GROUND_SWITCH_CTL,
  input  wire logic [3:0] PULL_CTL,
  input  wire logic [1:0] PUMP_CTL,
  // Analogue comparator and detector levels
  input  wire logic       SUPPLY_VALID_CMP,
  input  wire logic       SESSION_VALID_CMP,
  input  wire logic       SESSION_END_CMP,
  input  wire logic       ID_FLOATING_FLAG_CMP,
  input  wire logic       ID_GROUND_CMP,
  input  wire logic       CARKIT_CMP,
  // Digital data pins
  input  wire logic       OE_N,
  input  wire logic       DATA_OR_PLUS_PIN_IN,
  output logic            DATA_OR_PLUS_PIN_OUT,
  output logic            DATA_OR_PLUS_PIN_OE_N,
  input  wire logic       ZERO_OR_MINUS_PIN_IN,
  output logic            ZERO_OR_MINUS_PIN_OUT,
  output logic            ZERO_OR_MINUS_PIN_OE_N,
  // Line transceiver
  input  wire logic       LINE_PLUS_RX,
  input  wire logic       LINE_MINUS_RX,
  output logic            LINE_PLUS_TX,
  output logic            LINE_MINUS_TX,
  output logic            LINE_TX_EN,
  output logic            DIFF_RX_OUT,
  output logic            LINE_DIFF_RX_EN,
  // Analogue controls
  output logic            PUMP_DRIVE_5V,
  output logic            PUMP_PULLUP_3V3,
  output logic            PUMP_DISCHARGE,
  output logic            ID_GROUND_SWITCH,
  output logic            DP_PULLUP,
  output logic            DP_PULLDOWN,
  output logic            DM_PULLUP,
  output logic            DM_PULLDOWN,
  // Status bits read by the controller
  output logic            SUPPLY_FAULT,
  output logic            SESSION_VALID,
  output logic            SESSION_END,
  output logic            ID_FLOATING_FLAG,
  output logic            ID_GROUNDED_FLAG,
  output logic            CARKIT_FLAG
);

  // ---------------------------------------------------------------
  // Reset combine
  // ---------------------------------------------------------------
  logic rst_any;
  assign rst_any = RST | ~RESET_N;

  // ---------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------
  logic [6:0] raw_in;
  logic [6:0] syn;

  assign raw_in = {OE_N, CARKIT_CMP, ID_GROUND_CMP, ID_FLOATING_FLAG_CMP,
                   SESSION_END_CMP, SESSION_VALID_CMP, SUPPLY_VALID_CMP};

  genvar gi;
  generate
    for (gi = 0; gi < 7; gi++) begin : g_sync
      otgtc_sync u_sync (
        .clk  (CLK),
        .rst  (rst_any),
        .din  (raw_in[gi]),
        .dout (syn[gi])
      );
    end
  endgenerate

  // ---------------------------------------------------------------
  // Status and control registers
  // ---------------------------------------------------------------
  logic       fault_r,   fault_nxt;
  logic       sessv_r,   sessv_nxt;
  logic       sesse_r,   sesse_nxt;
  logic [1:0] id_r,      id_nxt;
  logic       carkit_r,  carkit_nxt;
  logic       idsw_r,    idsw_nxt;
  logic [3:0] pull_r,    pull_nxt;
  otgtc_pkg::otgtc_pump_t pump_r, pump_nxt;

  always_comb begin
    fault_nxt  = ~syn[0];
    sessv_nxt  = syn[1];
    sesse_nxt  = syn[2];
    // Detector keeps running while suspended
    if (syn[3] && syn[4]) begin
      id_nxt = id_r;
    end else begin
      id_nxt = {syn[4], syn[3]};
    end
    carkit_nxt = AUDIO_ENABLE & syn[5];
    idsw_nxt   = ID_GROUND_SWITCH_CTL;
    pull_nxt   = PULL_CTL;
    pump_nxt   = otgtc_pkg::otgtc_pump_t'(PUMP_CTL);
  end

  always_ff @(posedge CLK or posedge rst_any) begin
    if (rst_any) begin
      fault_r  <= otgtc_pkg::CTL_RST_VAL;
      sessv_r  <= otgtc_pkg::CTL_RST_VAL;
      sesse_r  <= otgtc_pkg::CTL_RST_VAL;
      id_r     <= otgtc_pkg::ID_RST_VAL;
      carkit_r <= otgtc_pkg::CTL_RST_VAL;
      idsw_r   <= otgtc_pkg::CTL_RST_VAL;
      pull_r   <= otgtc_pkg::PULL_RST_VAL;
      pump_r   <= otgtc_pkg::OTGTC_PUMP_OFF;
    end else begin
      fault_r  <= fault_nxt;
      sessv_r  <= sessv_nxt;
      sesse_r  <= sesse_nxt;
      id_r     <= id_nxt;
      carkit_r <= carkit_nxt;
      idsw_r   <= idsw_nxt;
      pull_r   <= pull_nxt;
      pump_r   <= pump_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Pump mode decode, one mode at a time
  // ---------------------------------------------------------------
  always_comb begin
    PUMP_DRIVE_5V   = 1'h0;
    PUMP_PULLUP_3V3 = 1'h0;
    PUMP_DISCHARGE  = 1'h0;
    unique case (pump_r)
      otgtc_pkg::OTGTC_PUMP_OFF:       PUMP_DRIVE_5V   = 1'h0;
      otgtc_pkg::OTGTC_PUMP_DRIVE:     PUMP_DRIVE_5V   = 1'h1;
      otgtc_pkg::OTGTC_PUMP_PULLUP:    PUMP_PULLUP_3V3 = 1'h1;
      otgtc_pkg::OTGTC_PUMP_DISCHARGE: PUMP_DISCHARGE  = 1'h1;
    endcase
  end

  assign ID_GROUND_SWITCH = idsw_r;
  assign DP_PULLUP        = pull_r[otgtc_pkg::PULL_DP_UP];
  assign DP_PULLDOWN      = pull_r[otgtc_pkg::PULL_DP_DN];
  assign DM_PULLUP        = pull_r[otgtc_pkg::PULL_DM_UP];
  assign DM_PULLDOWN      = pull_r[otgtc_pkg::PULL_DM_DN];

  assign SUPPLY_FAULT     = fault_r;
  assign SESSION_VALID    = sessv_r;
  assign SESSION_END      = sesse_r;
  assign ID_FLOATING_FLAG = id_r[0];
  assign ID_GROUNDED_FLAG = id_r[1];
  assign CARKIT_FLAG      = carkit_r;

  // ---------------------------------------------------------------
  // Data path selection
  // ---------------------------------------------------------------
  otgtc_pkg::otgtc_path_t path;
  logic                   pass_mode;

  assign pass_mode = TRANSPARENT_MODE_ENABLE | UART_ENABLE;

  always_comb begin
    if (pass_mode) begin
      path = otgtc_pkg::OTGTC_MODE_PASS;
    end else if (syn[6]) begin
      path = otgtc_pkg::OTGTC_MODE_USB_RX;
    end else begin
      path = otgtc_pkg::OTGTC_MODE_USB_TX;
    end
  end

  otgtc_pins u_pins (
    .path         (path),
    .encoded_mode (ENCODED_DATA_USB_MODE),
    .dat_in       (DATA_OR_PLUS_PIN_IN),
    .zero_in      (ZERO_OR_MINUS_PIN_IN),
    .dat_out      (DATA_OR_PLUS_PIN_OUT),
    .dat_oe_n     (DATA_OR_PLUS_PIN_OE_N),
    .zero_out     (ZERO_OR_MINUS_PIN_OUT),
    .zero_oe_n    (ZERO_OR_MINUS_PIN_OE_N),
    .line_p       (LINE_PLUS_RX),
    .line_m       (LINE_MINUS_RX),
    .tx_p         (LINE_PLUS_TX),
    .tx_m         (LINE_MINUS_TX),
    .tx_en        (LINE_TX_EN)
  );

  // Differential receiver powered down while suspended
  assign LINE_DIFF_RX_EN = ~SUSPEND_REQ & ~pass_mode;
  assign DIFF_RX_OUT     = LINE_DIFF_RX_EN & LINE_PLUS_RX & ~LINE_MINUS_RX;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (rst_any);

  pump_onehot_a: assert property (
    $onehot0({PUMP_DRIVE_5V, PUMP_PULLUP_3V3, PUMP_DISCHARGE}))
    else $error("pump modes overlap");

  carkit_gate_a: assert property (
    !AUDIO_ENABLE ##1 !AUDIO_ENABLE |-> !CARKIT_FLAG)
    else $error("carkit flag without audio");

  id_excl_a: assert property (
    !(ID_FLOATING_FLAG && ID_GROUNDED_FLAG))
    else $error("both id flags set");

  fault_track_a: assert property (
    $past(syn[0]) |-> !SUPPLY_FAULT)
    else $error("fault with valid supply");

  idsw_follow_a: assert property (
    $changed(ID_GROUND_SWITCH_CTL) |=> ID_GROUND_SWITCH == $past(ID_GROUND_SWITCH_CTL))
    else $error("id switch not following");

  rx_drive_a: assert property (
    (!pass_mode && syn[6]) |-> (!DATA_OR_PLUS_PIN_OE_N && !ZERO_OR_MINUS_PIN_OE_N))
    else $error("data pins not driven in receive");

  tx_float_a: assert property (
    (!pass_mode && !syn[6]) |-> (DATA_OR_PLUS_PIN_OE_N && LINE_TX_EN))
    else $error("data pins driven in transmit");

  pass_float_a: assert property (
    pass_mode |-> (DATA_OR_PLUS_PIN_OE_N && LINE_PLUS_TX == DATA_OR_PLUS_PIN_IN))
    else $error("pass mode not transparent");

  id_hold_a: assert property (
    (syn[3] && syn[4]) |=> $stable({ID_GROUNDED_FLAG, ID_FLOATING_FLAG}))
    else $error("id flags moved with both detectors high");

  id_track_a: assert property (
    !(syn[3] && syn[4]) |=> {ID_GROUNDED_FLAG, ID_FLOATING_FLAG} == $past({syn[4], syn[3]}))
    else $error("id flags not following detector");

  sessv_track_a: assert property (
    SESSION_VALID == $past(syn[1]))
    else $error("session valid not following comparator");

  sesse_track_a: assert property (
    SESSION_END == $past(syn[2]))
    else $error("session end not following comparator");

  pull_follow_a: assert property (
    $changed(PULL_CTL) |=>
      {DM_PULLDOWN, DM_PULLUP, DP_PULLDOWN, DP_PULLUP} == $past(PULL_CTL))
    else $error("pull resistors not following control");

  carkit_pass_a: assert property (
    (AUDIO_ENABLE && syn[5]) |=> CARKIT_FLAG)
    else $error("carkit flag missing in audio mode");

  pump_drive_a: assert property (
    (PUMP_CTL == otgtc_pkg::OTGTC_PUMP_DRIVE) |=> PUMP_DRIVE_5V)
    else $error("pump not driving on request");

  enc_tx_a: assert property (
    (path == otgtc_pkg::OTGTC_MODE_USB_TX && ENCODED_DATA_USB_MODE && ZERO_OR_MINUS_PIN_IN)
      |-> (!LINE_PLUS_TX && !LINE_MINUS_TX))
    else $error("single-ended zero not sent on line");

  rx_split_a: assert property (
    (path == otgtc_pkg::OTGTC_MODE_USB_RX && !ENCODED_DATA_USB_MODE)
      |-> (DATA_OR_PLUS_PIN_OUT == LINE_PLUS_RX && ZERO_OR_MINUS_PIN_OUT == LINE_MINUS_RX))
    else $error("split receive levels wrong");

  rx_suspend_a: assert property (
    SUSPEND_REQ |-> (!LINE_DIFF_RX_EN && !DIFF_RX_OUT))
    else $error("differential receiver on in suspend");

  // ---------------------------------------------------------------
  // Cover points
  // ---------------------------------------------------------------
  cov_rx_c:     cover property (!pass_mode && syn[6]);
  cov_carkit_c: cover property (CARKIT_FLAG);
  cov_pump_c:   cover property (PUMP_PULLUP_3V3 ##1 PUMP_DISCHARGE);
  cov_idhold_c: cover property (syn[3] && syn[4]);
  cov_enctx_c:  cover property (path == otgtc_pkg::OTGTC_MODE_USB_TX && ENCODED_DATA_USB_MODE);

endmodule

// ---- core/otgtc_pkg.sv ----
package otgtc_pkg;

  // ---------------------------------------------------------------
  // Reset values of control bits
  // ---------------------------------------------------------------
  localparam logic       CTL_RST_VAL      = 1'h0;
  localparam logic [2:0] STAT_RST_VAL     = 3'h0;
  localparam logic [1:0] ID_RST_VAL       = 2'h0;
  localparam logic [3:0] PULL_RST_VAL     = 4'h0;

  // ---------------------------------------------------------------
  // Field positions of the pull resistor control word
  // ---------------------------------------------------------------
  localparam int PULL_DP_UP = 0;
  localparam int PULL_DP_DN = 1;
  localparam int PULL_DM_UP = 2;
  localparam int PULL_DM_DN = 3;

  // ---------------------------------------------------------------
  // Synchroniser depth
  // ---------------------------------------------------------------
  localparam int SYNC_DEPTH = 3;

  // ---------------------------------------------------------------
  // Operating modes
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    OTGTC_PUMP_OFF,
    OTGTC_PUMP_DRIVE,
    OTGTC_PUMP_PULLUP,
    OTGTC_PUMP_DISCHARGE
  } otgtc_pump_t;

  typedef enum logic [1:0] {
    OTGTC_MODE_USB_TX,
    OTGTC_MODE_USB_RX,
    OTGTC_MODE_PASS
  } otgtc_path_t;

endpackage

// ---- core/otgtc_sync.sv ----
`timescale 1ns/1ps
module otgtc_sync (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Asynchronous level in, filtered level out
  input  wire logic din,
  output logic      dout
);

  logic [otgtc_pkg::SYNC_DEPTH-1:0] sh_r;
  logic [otgtc_pkg::SYNC_DEPTH-1:0] sh_nxt;
  logic                             dout_r;
  logic                             dout_nxt;

  // ---------------------------------------------------------------
  // Three stages; the level changes once stages two and three agree
  // ---------------------------------------------------------------
  always_comb begin
    sh_nxt   = {sh_r[otgtc_pkg::SYNC_DEPTH-2:0], din};
    dout_nxt = (sh_r[1] == sh_r[2]) ? sh_r[2] : dout_r;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sh_r   <= '0;
      dout_r <= otgtc_pkg::CTL_RST_VAL;
    end else begin
      sh_r   <= sh_nxt;
      dout_r <= dout_nxt;
    end
  end

  assign dout = dout_r;

endmodule

// ---- core/otgtc_pins.sv ----
`timescale 1ns/1ps
module otgtc_pins (
  // Path selection
  input  otgtc_pkg::otgtc_path_t path,
  input  wire logic              encoded_mode,
  // Digital data pins
  input  wire logic              dat_in,
  input  wire logic              zero_in,
  output logic                   dat_out,
  output logic                   dat_oe_n,
  output logic                   zero_out,
  output logic                   zero_oe_n,
  // Line side
  input  wire logic              line_p,
  input  wire logic              line_m,
  output logic                   tx_p,
  output logic                   tx_m,
  output logic                   tx_en
);

  // ---------------------------------------------------------------
  // Direction and encoding of the data pins
  // ---------------------------------------------------------------
  always_comb begin
    dat_out   = 1'h0;
    zero_out  = 1'h0;
    dat_oe_n  = 1'h1;
    zero_oe_n = 1'h1;
    tx_p      = 1'h0;
    tx_m      = 1'h0;
    tx_en     = 1'h0;
    unique case (path)
      otgtc_pkg::OTGTC_MODE_USB_TX: begin
        tx_en = 1'h1;
        if (encoded_mode) begin
          tx_p = dat_in & ~zero_in;
          tx_m = ~dat_in & ~zero_in;
        end else begin
          tx_p = dat_in;
          tx_m = zero_in;
        end
      end
      otgtc_pkg::OTGTC_MODE_USB_RX: begin
        dat_oe_n  = 1'h0;
        zero_oe_n = 1'h0;
        if (encoded_mode) begin
          dat_out  = line_p;
          zero_out = ~line_p & ~line_m;
        end else begin
          dat_out  = line_p;
          zero_out = line_m;
        end
      end
      otgtc_pkg::OTGTC_MODE_PASS: begin
        tx_en = 1'h1;
        tx_p  = dat_in;
        tx_m  = zero_in;
      end
      default: begin
        tx_en = 1'h0;
      end
    endcase
  end

endmodule

// ---- tb/otgtc_ctl_model.sv ----
`timescale 1ns/1ps
module otgtc_ctl_model (
  // Device side of one data pin
  input  wire logic dev_out,
  input  wire logic dev_oe_n,
  // Controller drive request
  input  wire logic drv_en,
  input  wire logic drv_val,
  // Resolved pin level
  output logic      pin
);
  logic last_r = 1'h0;

  // ---------------------------------------------------------------
  // Wire resolution
  // ---------------------------------------------------------------
  // Controller drives only on request, never while the device drives
  always_comb begin
    if (!dev_oe_n) begin
      pin = dev_out;
    end else if (drv_en) begin
      pin = drv_val;
    end else begin
      pin = ~last_r;
    end
  end

  // Released wire shows the inverse of its last level
  always @(pin) begin
    if (!dev_oe_n || drv_en) begin
      last_r = pin;
    end
  end
endmodule

// ---- tb/tb.sv ----
`timescale 1ns/1ps
module tb;
  typedef struct {string nm; logic [22:0] m; logic [22:0] e;} otgtc_note_t;
  logic clk, rst, rst_n, transp, uart, enc, audio, susp, idsw, vld, sval, send, idf, idg, car;
  logic oe_n, lp, lm, d_en, d_v, z_v, smp;
  logic [3:0]  pull;
  logic [1:0]  pump;
  logic [22:0] mk, e;
  wire logic [22:0] obs;
  wire logic d_pin, z_pin;
  int n_mismatch = 0, n_checks = 0, cycles = 0, md, seed = 32'h509a;
  otgtc_note_t q[$], nt;

  otgtc_top otgtc_top_inst (
    .CLK(clk), .RST(rst), .RESET_N(rst_n), .TRANSPARENT_MODE_ENABLE(transp),
    .UART_ENABLE(uart), .ENCODED_DATA_USB_MODE(enc), .AUDIO_ENABLE(audio),
    .SUSPEND_REQ(susp), .ID_GROUND_SWITCH_CTL(idsw), .PULL_CTL(pull), .PUMP_CTL(pump),
    .SUPPLY_VALID_CMP(vld), .SESSION_VALID_CMP(sval), .SESSION_END_CMP(send),
    .ID_FLOATING_FLAG_CMP(idf), .ID_GROUND_CMP(idg), .CARKIT_CMP(car), .OE_N(oe_n),
    .DATA_OR_PLUS_PIN_IN(d_pin), .DATA_OR_PLUS_PIN_OUT(obs[14]),
    .DATA_OR_PLUS_PIN_OE_N(obs[15]), .ZERO_OR_MINUS_PIN_IN(z_pin),
    .ZERO_OR_MINUS_PIN_OUT(obs[16]), .ZERO_OR_MINUS_PIN_OE_N(obs[17]),
    .LINE_PLUS_RX(lp), .LINE_MINUS_RX(lm), .LINE_PLUS_TX(obs[18]), .LINE_MINUS_TX(obs[19]),
    .LINE_TX_EN(obs[20]), .DIFF_RX_OUT(obs[21]), .LINE_DIFF_RX_EN(obs[22]),
    .PUMP_DRIVE_5V(obs[0]), .PUMP_PULLUP_3V3(obs[1]), .PUMP_DISCHARGE(obs[2]),
    .ID_GROUND_SWITCH(obs[3]), .DP_PULLUP(obs[4]), .DP_PULLDOWN(obs[5]),
    .DM_PULLUP(obs[6]), .DM_PULLDOWN(obs[7]), .SUPPLY_FAULT(obs[8]),
    .SESSION_VALID(obs[9]), .SESSION_END(obs[10]), .ID_FLOATING_FLAG(obs[11]),
    .ID_GROUNDED_FLAG(obs[12]), .CARKIT_FLAG(obs[13])
  );
  otgtc_ctl_model otgtc_ctl_model_inst (
    .dev_out(obs[14]), .dev_oe_n(obs[15]), .drv_en(d_en), .drv_val(d_v), .pin(d_pin)
  );
  otgtc_ctl_model otgtc_ctl_model_zero_inst (
    .dev_out(obs[16]), .dev_oe_n(obs[17]), .drv_en(d_en), .drv_val(z_v), .pin(z_pin)
  );

  initial begin
    clk = 1'h0;
    forever #50 clk = ~clk;
  end

  // ---------------------------------------------------------------
  // Notes, monitor and verdict
  // ---------------------------------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #10;
  endtask

  task automatic note(input string nm, input logic [22:0] m, input logic [22:0] x);
    q.push_back('{nm, m, x});
    smp = 1'h1;
    #1 smp = 1'h0;
  endtask

  task automatic check(input string nm, input logic [22:0] seen, input logic [22:0] x);
    n_checks++;
    if (seen !== x) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, x, seen);
    end
  endtask

  task automatic close_out;
    if (n_mismatch == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  always @(posedge smp) begin
    nt = q.pop_front();
    check(nt.nm, obs & nt.m, nt.e & nt.m);
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      n_mismatch++;
      close_out();
    end
  end

  // ---------------------------------------------------------------
  // Stimulus
  // ---------------------------------------------------------------
  initial begin
    {transp, uart, enc, audio, susp, idsw, vld, sval, send, idf, idg, car} = 12'h0;
    {oe_n, lp, lm, d_en, d_v, z_v, smp, pull, pump} = 13'h0;
    rst = 1'h1;
    rst_n = 1'h1;
    repeat (4) @(posedge clk);
    #10 rst = 1'h0;
    for (int i = 0; i < 4; i++) begin
      pump = 2'(i);
      cyc(1);
      note("pump", 23'h7, (i == 0) ? 23'h0 : 23'(1 << (i - 1)));
    end
    for (int i = 0; i < 8; i++) begin
      pull = 4'($random(seed));
      idsw = 1'($random(seed));
      cyc(1);
      note("pull", 23'hf8, {15'h0, pull, idsw, 3'h0});
    end
    // Status is read only once settled, never during supply power-up
    // Both detectors high follows floating, so the held flags read floating
    for (int i = 0; i < 12; i++) begin
      {vld, sval, send, car, audio, susp} = 6'($random(seed));
      {idf, idg} = (i % 4 == 0) ? 2'h2 : (i % 4 == 1) ? 2'h3 : (i % 4 == 2) ? 2'h1 : 2'h0;
      cyc(6);
      e = {9'h0, car & audio, idg & ~idf, idf, send, sval, ~vld, 8'h0};
      note("status", 23'h3f00, e);
    end
    for (int i = 0; i < 16; i++) begin
      md = i % 4;
      {lp, lm, d_v, z_v, enc, susp, oe_n} = 7'($random(seed));
      oe_n = (md < 2) ? (md == 0) : oe_n;
      transp = md == 2;
      uart = md == 3;
      d_en = md != 0;
      cyc(6);
      mk = 23'h728000;
      e = 23'h0;
      {e[22], e[20], e[17], e[15]} = {(md < 2) & ~susp, {3{md != 0}}};
      e[21] = (md < 2) & ~susp & lp & ~lm;
      if (md == 0) begin
        mk[16] = 1'h1;
        e[16] = enc ? ~(lp | lm) : lm;
        mk[14] = !enc;
        e[14] = lp;
      end else begin
        mk[19:18] = 2'h3;
        e[19:18] = (md == 1 && enc) ? {~(d_v | z_v), d_v & ~z_v} : {z_v, d_v};
      end
      note("pins", mk, e);
    end
    rst_n = 1'h0;
    pump = 2'h1;
    pull = 4'hf;
    cyc(1);
    note("reset", 23'h3fff, 23'h0);
    rst_n = 1'h1;
    cyc(2);
    note("release", 23'hff, {15'h0, 4'hf, idsw, 3'h1});
    cyc(2);
    close_out();
  end
endmodule
